// ==== common/stmp_pkg.sv ====
// Package: constants, states and carriers for the SCSI target message and phase control block
package stmp_pkg;

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SENSE  = 8'h08;
  localparam logic [7:0] REG_RETRY  = 8'h0C;

  // Control register field positions
  localparam int CTRL_PARITY_EN   = 0;
  localparam int CTRL_DISC_REQ    = 1;
  localparam int CTRL_RESEL_REQ   = 2;
  localparam int CTRL_CMD_DONE    = 3;
  localparam int CTRL_WRITE_CMD   = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Message codes
  localparam logic [7:0] MSG_COMPLETE   = 8'h00;
  localparam logic [7:0] MSG_RESTORE    = 8'h03;
  localparam logic [7:0] MSG_DISCONNECT = 8'h04;
  localparam logic [7:0] MSG_INIT_ERR   = 8'h05;
  localparam logic [7:0] MSG_ABORT      = 8'h06;
  localparam logic [7:0] MSG_REJECT     = 8'h07;
  localparam logic [7:0] MSG_DEV_RESET  = 8'h0C;

  // Identify byte layout
  localparam int ID_FLAG_BIT   = 7;
  localparam int ID_DISC_BIT   = 6;
  localparam int ID_ROUTINE_BIT = 5;
  localparam int ID_LUN_HI     = 2;
  localparam logic [2:0] ID_LUN_VALUE = 3'h0;

  // Status and sense values
  localparam logic [7:0] STATUS_CHECK    = 8'h02;
  localparam logic [3:0] SENSE_ABORTED   = 4'hB;
  localparam logic [7:0] ASC_PARITY_CDB  = 8'h43;
  localparam logic [7:0] ASCQ_ZERO       = 8'h00;
  localparam logic [7:0] FSC_CDB_RETRY   = 8'hE0;

  // CDB retries: 15 retries, 16 attempts
  localparam logic [3:0] CDB_RETRY_MAX = 4'hF;

  // Reset values
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Bus phases driven by the target
  typedef enum logic [3:0] {
    ST_BUS_FREE   = 4'b0000,
    ST_MSG_OUT    = 4'b0001,
    ST_COMMAND    = 4'b0011,
    ST_DATA       = 4'b0010,
    ST_STATUS     = 4'b0110,
    ST_MSG_IN     = 4'b0111,
    ST_MSG_HOLD   = 4'b0101,
    ST_RESELECT   = 4'b0100,
    ST_MSG_IN_ID  = 4'b1100
  } stmp_state_t;

  // One byte taken from the bus with its handshake
  typedef struct packed {
    logic       valid;
    logic       parity_err;
    logic [7:0] data;
  } stmp_byte_t;

  // Sense data held for the initiator
  typedef struct packed {
    logic       bus_parity_error_flag;
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
    logic [7:0] fault_symptom_code;
  } stmp_sense_t;

  // Helper: CDB length from the group code in byte 0
  function automatic logic [3:0] stmp_cdb_len(input logic [7:0] op);
    case (op[7:5])
      3'h0:    stmp_cdb_len = 4'h6;
      3'h1,
      3'h2:    stmp_cdb_len = 4'hA;
      3'h5:    stmp_cdb_len = 4'hC;
      default: stmp_cdb_len = 4'h6;
    endcase
  endfunction

endpackage

// ==== hdl/stmp_ctrl.sv ====
// Target message and phase sequencer with APB control and status registers
// ============================================================
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module stmp_ctrl
  import stmp_pkg::*;
(
  input  wire logic              core_clk,       // 10 MHz core clock
  input  wire logic              rst,            // Sync reset, bus reset or power-on
  input  wire logic              psel,           // APB select
  input  wire logic              penable,        // APB enable
  input  wire logic              pwrite,         // APB direction
  input  wire logic [7:0]        paddr,          // APB byte address
  input  wire logic [31:0]       pwdata,         // APB write data
  output logic                   pready,         // APB ready
  output logic [31:0]            prdata,         // APB read data
  output logic                   pslverr,        // APB error, unmapped address
  input  wire logic              sel_done,       // Selection phase completed (pulse)
  input  wire logic              sel_atn,        // Attention seen during selection
  input  wire logic              sel_parity_err, // Parity error in selection
  input  wire logic              atn_pin,        // Attention pin, asynchronous
  input  wire stmp_pkg::stmp_byte_t rx_byte,     // Byte taken from initiator
  input  wire logic              tx_ack,         // Initiator took the sent byte
  input  wire logic              cmd_is_sense,   // Decoded command is sense or inquiry
  output stmp_pkg::stmp_state_t  phase,          // Current bus phase
  output logic                   busy_oe,        // Busy driven by target
  output logic                   tx_valid,       // Byte to send is valid
  output logic [7:0]             tx_data,        // Byte to send
  output logic                   cmd_ready,      // Full CDB received (pulse)
  output logic                   path_ok         // Identify has set up the path
);

  // ============================================================
  // Attention synchroniser
  logic atn_meta;
  logic atn_sync;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      atn_meta <= 1'b0;
      atn_sync <= 1'b0;
    end
    else
    begin
      atn_meta <= atn_pin;
      atn_sync <= atn_meta;
    end
  end

  // ============================================================
  // Registers
  logic [31:0] ctrl;
  stmp_sense_t sense;
  logic        disc_allowed;
  logic        first_seq;
  logic        msg_retried;
  logic        after_msg_out;
  logic        atn_pending;
  logic [3:0]  cdb_retry;
  logic [3:0]  cdb_count;
  logic [3:0]  cdb_len;
  logic        sel_perr_seen;
  logic        disconnected;
  logic        catastrophic;
  logic        cmd_start;

  wire parity_on = ctrl[CTRL_PARITY_EN];
  wire rx_ok     = rx_byte.valid && !(parity_on && rx_byte.parity_err);
  wire rx_bad    = rx_byte.valid && parity_on && rx_byte.parity_err;
  wire apb_wr    = psel && penable && pwrite;

  // ============================================================
  // APB slave, single wait-free access phase
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        case (paddr)
          REG_CTRL:   prdata <= ctrl;
          REG_STATUS: prdata <= {20'h00000, catastrophic, disconnected, disc_allowed, path_ok,
                                 msg_retried, sel_perr_seen, 2'h0, phase};
          REG_SENSE:  prdata <= {3'h0, sense.bus_parity_error_flag, sense.key, sense.asc,
                                 sense.ascq, sense.fault_symptom_code};
          REG_RETRY:  prdata <= {28'h0000000, cdb_retry};
          default:
          begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Control bits; request bits self-clear in the phase that serves them, whether acted on or not
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl <= CTRL_RESET;
    else if (apb_wr && pready && paddr == REG_CTRL)
      ctrl <= pwdata;
    else
    begin
      if (phase == ST_DATA && ctrl[CTRL_DISC_REQ])
        ctrl[CTRL_DISC_REQ] <= 1'b0;
      if (phase == ST_BUS_FREE && ctrl[CTRL_RESEL_REQ])
        ctrl[CTRL_RESEL_REQ] <= 1'b0;
      if (phase == ST_DATA && ctrl[CTRL_CMD_DONE])
        ctrl[CTRL_CMD_DONE] <= 1'b0;
    end
  end

  // ============================================================
  // Sense data
  always_ff @(posedge core_clk)
  begin
    if (rst)
      sense <= '0;
    else if (phase == ST_COMMAND && rx_bad && cdb_retry == CDB_RETRY_MAX)
      sense <= '{1'b1, SENSE_ABORTED, ASC_PARITY_CDB, ASCQ_ZERO, FSC_CDB_RETRY};
    else if (phase == ST_COMMAND && rx_bad && !path_ok)
      sense <= '{1'b1, SENSE_ABORTED, BYTE_ZERO, BYTE_ZERO, BYTE_ZERO};
    else if (phase == ST_DATA && rx_bad && ctrl[CTRL_WRITE_CMD] && !path_ok)
      sense <= '{1'b1, SENSE_ABORTED, BYTE_ZERO, BYTE_ZERO, BYTE_ZERO};
    else if (cmd_start && !cmd_is_sense)
      sense <= '0;
  end

  // ============================================================
  // Phase sequencer
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      phase         <= ST_BUS_FREE;
      busy_oe       <= 1'b0;
      tx_valid      <= 1'b0;
      tx_data       <= BYTE_ZERO;
      cmd_ready     <= 1'b0;
      path_ok       <= 1'b0;
      disc_allowed  <= 1'b0;
      first_seq     <= 1'b0;
      msg_retried   <= 1'b0;
      after_msg_out <= 1'b0;
      atn_pending   <= 1'b0;
      cdb_retry     <= 4'h0;
      cdb_count     <= 4'h0;
      cdb_len       <= 4'h6;
      sel_perr_seen <= 1'b0;
      disconnected  <= 1'b0;
      catastrophic  <= 1'b0;
      cmd_start     <= 1'b0;
    end
    else
    begin
      cmd_ready <= 1'b0;
      cmd_start <= 1'b0;
      case (phase)
        ST_BUS_FREE:
        begin
          busy_oe  <= 1'b0;
          tx_valid <= 1'b0;
          if (sel_done)
          begin
            busy_oe       <= 1'b1;
            cdb_retry     <= 4'h0;
            msg_retried   <= 1'b0;
            sel_perr_seen <= sel_parity_err;
            catastrophic  <= 1'b0;
            after_msg_out <= 1'b0;
            first_seq     <= 1'b1;
            cdb_count     <= 4'h0;
            disconnected  <= 1'b0;
            if (sel_atn)
              phase <= sel_parity_err ? ST_MSG_HOLD : ST_MSG_OUT;
            else
            begin
              path_ok <= 1'b0;
              phase   <= ST_COMMAND;
            end
          end
          else if (disconnected && ctrl[CTRL_RESEL_REQ])
          begin
            busy_oe <= 1'b1;
            phase   <= ST_RESELECT;
          end
        end
        ST_MSG_HOLD:
          if (!atn_sync)
          begin
            sel_perr_seen <= 1'b0;
            phase         <= ST_MSG_OUT;
          end
        ST_MSG_OUT:
          if (rx_bad)
          begin
            if (msg_retried)
            begin
              busy_oe <= 1'b0;
              phase   <= ST_BUS_FREE;
            end
            else
            begin
              msg_retried <= 1'b1;
              phase       <= ST_MSG_HOLD;
            end
          end
          else if (rx_ok)
          begin
            msg_retried <= 1'b0;
            if (first_seq)
            begin
              first_seq <= 1'b0;
              if (rx_byte.data[ID_FLAG_BIT] && !rx_byte.data[ID_ROUTINE_BIT]
                  && rx_byte.data[ID_LUN_HI:0] == ID_LUN_VALUE)
              begin
                path_ok      <= 1'b1;
                disc_allowed <= rx_byte.data[ID_DISC_BIT];
                phase        <= atn_sync ? ST_MSG_OUT : ST_COMMAND;
              end
              else
              begin
                // Abort, device reset, or anything illegal ends the nexus
                busy_oe <= 1'b0;
                path_ok <= 1'b0;
                phase   <= ST_BUS_FREE;
              end
            end
            else if (rx_byte.data == MSG_ABORT || rx_byte.data == MSG_DEV_RESET
                     || ((rx_byte.data == MSG_REJECT || rx_byte.data == MSG_INIT_ERR) && after_msg_out))
            begin
              catastrophic <= rx_byte.data != MSG_ABORT && rx_byte.data != MSG_DEV_RESET;
              busy_oe      <= 1'b0;
              path_ok      <= 1'b0;
              phase        <= ST_BUS_FREE;
            end
            else if (atn_sync)
              phase <= ST_MSG_OUT;
            else
            begin
              after_msg_out <= 1'b1;
              phase         <= (cdb_count == cdb_len && cdb_count != 4'h0) ? ST_DATA : ST_COMMAND;
            end
          end
        ST_COMMAND:
          if (rx_bad)
          begin
            cdb_count <= 4'h0;
            if (!path_ok)
            begin
              tx_valid <= 1'b1;
              tx_data  <= STATUS_CHECK;
              phase    <= ST_STATUS;
            end
            else if (cdb_retry == CDB_RETRY_MAX)
            begin
              tx_valid <= 1'b1;
              tx_data  <= STATUS_CHECK;
              phase    <= ST_STATUS;
            end
            else
            begin
              cdb_retry <= cdb_retry + 4'h1;
              tx_valid  <= 1'b1;
              tx_data   <= MSG_RESTORE;
              phase     <= ST_MSG_IN;
            end
          end
          else if (rx_ok)
          begin
            if (cdb_count == 4'h0)
            begin
              cdb_len   <= stmp_cdb_len(rx_byte.data);
              cmd_start <= 1'b1;
            end
            cdb_count <= cdb_count + 4'h1;
            if ((cdb_count == 4'h0 ? stmp_cdb_len(rx_byte.data) : cdb_len) == cdb_count + 4'h1)
            begin
              cmd_ready <= 1'b1;
              // Attention held back until the last CDB byte
              phase     <= (atn_sync && path_ok) ? ST_MSG_OUT : ST_DATA;
            end
          end
        ST_DATA:
          if (rx_bad && ctrl[CTRL_WRITE_CMD] && !path_ok)
          begin
            tx_valid <= 1'b1;
            tx_data  <= STATUS_CHECK;
            phase    <= ST_STATUS;
          end
          else if ((rx_ok || tx_ack) && atn_sync && path_ok)
            phase <= ST_MSG_OUT;
          else if (ctrl[CTRL_DISC_REQ] && disc_allowed)
          begin
            tx_valid <= 1'b1;
            tx_data  <= MSG_DISCONNECT;
            phase    <= ST_MSG_IN;
          end
          else if (ctrl[CTRL_CMD_DONE])
          begin
            tx_valid <= 1'b1;
            tx_data  <= STATUS_CHECK & {8{sense.bus_parity_error_flag}};
            phase    <= ST_STATUS;
          end
        ST_STATUS:
          if (tx_ack)
          begin
            tx_data <= MSG_COMPLETE;
            phase   <= (atn_sync && path_ok) ? ST_MSG_OUT : ST_MSG_IN;
            tx_valid <= !(atn_sync && path_ok);
          end
        ST_MSG_IN:
          if (tx_ack)
          begin
            tx_valid <= 1'b0;
            if (atn_sync && path_ok)
              phase <= ST_MSG_OUT;
            else if (tx_data == MSG_RESTORE)
              phase <= ST_COMMAND;
            else
            begin
              disconnected <= tx_data == MSG_DISCONNECT;
              busy_oe      <= 1'b0;
              phase        <= ST_BUS_FREE;
            end
          end
        ST_RESELECT:
        begin
          tx_valid <= 1'b1;
          tx_data  <= {1'b1, disc_allowed, 3'h0, ID_LUN_VALUE};
          phase    <= ST_MSG_IN_ID;
        end
        ST_MSG_IN_ID:
          if (tx_ack)
          begin
            tx_valid     <= 1'b0;
            disconnected <= 1'b0;
            phase        <= ST_DATA;
          end
        default:
        begin
          busy_oe <= 1'b0;
          phase   <= ST_BUS_FREE;
        end
      endcase
    end
  end

endmodule

// ==== verification/stmp_init_model.sv ====
// Initiator model: takes each byte the target offers, promptly or slowly
`timescale 1ns/1ps

module stmp_init_model
(
  input  wire logic       core_clk, // Core clock
  input  wire logic       rst,      // Sync reset
  input  wire logic       slow,     // Stretch the answer
  input  wire logic [2:0] dly,      // Extra wait when slow
  input  wire logic       tx_valid, // Target offers a byte
  output logic            tx_ack    // Byte taken, one-cycle pulse
);
  logic [2:0] gap;

  // ============================================================
  // Acknowledge
  // Gap after each pulse: tx_valid of the old byte still shows for one edge
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_ack <= 1'b0;
      gap    <= 3'h0;
    end
    else if (tx_ack)
    begin
      tx_ack <= 1'b0;
      gap    <= slow ? dly : 3'h0;
    end
    else if (gap != 3'h0)
      gap <= gap - 3'h1;
    else if (tx_valid)
      tx_ack <= 1'b1;
  end
endmodule

// ==== verification/stmp_ctrl_checker.sv ====
// Concurrent assertions on the ports of the target phase controller
`timescale 1ns/1ps

module stmp_ctrl_checker
  import stmp_pkg::*;
(
  input wire logic                  core_clk,       // Core clock
  input wire logic                  rst,            // Sync reset
  input wire logic                  psel,           // APB select
  input wire logic                  penable,        // APB enable
  input wire logic                  pwrite,         // APB direction
  input wire logic [7:0]            paddr,          // APB address
  input wire logic [31:0]           pwdata,         // APB write data
  input wire logic                  pready,         // APB ready
  input wire logic [31:0]           prdata,         // APB read data
  input wire logic                  pslverr,        // APB error
  input wire logic                  sel_done,       // Selection finished
  input wire logic                  sel_atn,        // Attention at selection
  input wire logic                  sel_parity_err, // Selection parity error
  input wire logic                  atn_pin,        // Attention pin
  input wire stmp_pkg::stmp_byte_t  rx_byte,        // Byte from initiator
  input wire logic                  tx_ack,         // Byte taken by initiator
  input wire logic                  cmd_is_sense,   // Sense or inquiry command
  input wire stmp_pkg::stmp_state_t phase,          // Bus phase
  input wire logic                  busy_oe,        // Busy driven
  input wire logic                  tx_valid,       // Byte offered
  input wire logic [7:0]            tx_data,        // Byte offered
  input wire logic                  cmd_ready,      // Full CDB
  input wire logic                  path_ok         // Path set up
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ============================================================
  // Sequences and properties
  sequence s_apb_setup;
    psel && !penable;
  endsequence
  sequence s_sel_atn;
    sel_done && sel_atn && !sel_parity_err && phase == ST_BUS_FREE;
  endsequence
  sequence s_cdb_bad;
    phase == ST_COMMAND && rx_byte.valid && rx_byte.parity_err;
  endsequence
  sequence s_identify;
    phase == ST_MSG_OUT && !path_ok && rx_byte.valid && !rx_byte.parity_err && rx_byte.data[7]
      && !rx_byte.data[5] && rx_byte.data[2:0] == ID_LUN_VALUE;
  endsequence

  property p_apb_ready;
    s_apb_setup |=> pready;
  endproperty
  property p_apb_err;
    pslverr |-> pready;
  endproperty
  property p_sel_msg_out;
    s_sel_atn |=> phase == ST_MSG_OUT;
  endproperty
  property p_identify;
    s_identify |=> path_ok && phase == ($past(atn_pin, 3) ? ST_MSG_OUT : ST_COMMAND);
  endproperty
  property p_tx_hold;
    tx_valid && !tx_ack |=> tx_valid && $stable(tx_data);
  endproperty
  property p_cdb_retry;
    s_cdb_bad |=> tx_valid && ((phase == ST_MSG_IN && tx_data == MSG_RESTORE)
      || (phase == ST_STATUS && tx_data == STATUS_CHECK));
  endproperty
  property p_cmd_hold;
    phase == ST_COMMAND && !rx_byte.valid |=> phase == ST_COMMAND;
  endproperty
  property p_cmd_ready;
    $rose(cmd_ready) |-> $past(rx_byte.valid) && $past(phase) == ST_COMMAND;
  endproperty

  a_apb_ready: assert property (p_apb_ready) else $error("APB ready missing after setup");
  a_apb_err: assert property (p_apb_err) else $error("APB error without ready");
  a_sel_msg_out: assert property (p_sel_msg_out) else $error("No message out after selection");
  a_identify: assert property (p_identify) else $error("Identify did not set up the path");
  a_tx_hold: assert property (p_tx_hold) else $error("Offered byte dropped before ack");
  a_cdb_retry: assert property (p_cdb_retry) else $error("Bad CDB byte not answered");
  a_cmd_hold: assert property (p_cmd_hold) else $error("Command phase left early");
  a_cmd_ready: assert property (p_cmd_ready) else $error("CDB end without a byte");
endmodule

bind stmp_ctrl stmp_ctrl_checker u_chk (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .sel_done(sel_done), .sel_atn(sel_atn), .sel_parity_err(sel_parity_err), .atn_pin(atn_pin),
  .rx_byte(rx_byte), .tx_ack(tx_ack), .cmd_is_sense(cmd_is_sense), .phase(phase), .busy_oe(busy_oe),
  .tx_valid(tx_valid), .tx_data(tx_data), .cmd_ready(cmd_ready), .path_ok(path_ok));

// ==== verification/stmp_ctrl_tb_top.sv ====
// Self-checking testbench for the target phase controller
`timescale 1ns/1ps

module stmp_ctrl_tb_top;
  import stmp_pkg::*;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, sel_done, sel_atn, sel_parity_err;
  logic        atn_pin, tx_ack, tx_valid, cmd_ready, path_ok, busy_oe, slow, err, cmd_is_sense;
  logic [7:0]  paddr, tx_data;
  logic [31:0] pwdata, prdata, rd, rd2;
  logic [2:0]  dly;
  stmp_byte_t  rx_byte;
  stmp_state_t phase;
  logic [7:0]  exp_q[$];
  logic [7:0]  ops[3] = '{8'h08, 8'h28, 8'hA8};
  int          lens[3] = '{6, 10, 12};
  int          mismatches, n_tests, seed, cycles;

  stmp_ctrl DUT (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sel_done(sel_done), .sel_atn(sel_atn), .sel_parity_err(sel_parity_err), .atn_pin(atn_pin),
    .rx_byte(rx_byte), .tx_ack(tx_ack), .cmd_is_sense(cmd_is_sense), .phase(phase), .busy_oe(busy_oe),
    .tx_valid(tx_valid), .tx_data(tx_data), .cmd_ready(cmd_ready), .path_ok(path_ok));
  stmp_init_model u_init (.core_clk(core_clk), .rst(rst), .slow(slow), .dly(dly), .tx_valid(tx_valid),
    .tx_ack(tx_ack));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ============================================================
  // Result watcher and hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      mismatches++;
      end_of_test();
    end
    if (tx_valid === 1'b1 && tx_ack === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("tx_extra", {24'h0, tx_data}, 32'hFFFF);
      else
        check("tx_data", {24'h0, tx_data}, {24'h0, exp_q.pop_front()});
    end
  end

  // ============================================================
  // Drivers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic send(input logic [7:0] d, input logic pe);
    @(posedge core_clk);
    rx_byte <= '{1'b1, pe, d};
    @(posedge core_clk);
    rx_byte <= '{1'b0, 1'b0, 8'($random(seed))};
  endtask

  task automatic select;
    @(posedge core_clk);
    sel_done <= 1'b1;
    sel_atn  <= 1'b1;
    @(posedge core_clk);
    sel_done <= 1'b0;
    sel_atn  <= 1'b0;
  endtask

  // Starts one edge late: the launching edge's update must land first
  task automatic wait_phase(input stmp_state_t p);
    for (int i = 0; i < 60; i++)
    begin
      @(posedge core_clk);
      if (phase === p)
        break;
    end
    check("phase", {28'h0, phase}, {28'h0, p});
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    seed = 32'h0000EAB2;
    rst = 1'b1;
    {psel, penable, pwrite, sel_done, sel_atn, sel_parity_err, atn_pin, slow, cmd_is_sense} = 9'h000;
    paddr = 8'h00;
    pwdata = 32'h0;
    dly = 3'h0;
    rx_byte = '0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, REG_CTRL, 32'h0);
    check("ctrl_reset", rd, CTRL_RESET);
    apb(1'b0, 8'h10, 32'($random(seed)));
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("idle_busy", {31'h0, busy_oe}, 32'h0);
    // Group codes 0, 1 and 5, prompt and slow initiator
    foreach (ops[k])
    begin
      slow <= k[0];
      dly <= 3'($random(seed));
      select();
      wait_phase(ST_MSG_OUT);
      send(8'hC0, 1'b0);
      wait_phase(ST_COMMAND);
      check("path_ok", {31'h0, path_ok}, 32'h1);
      // Attention held through the whole CDB of the last group code
      atn_pin <= (k == 2);
      for (int i = 1; i < lens[k]; i++)
        send(i == 1 ? ops[k] : 8'($random(seed)), 1'b0);
      check("cdb_short", {28'h0, phase}, {28'h0, ST_COMMAND});
      send(8'($random(seed)), 1'b0);
      if (k == 2)
      begin
        wait_phase(ST_MSG_OUT);
        send(8'h08, 1'b0);
        wait_phase(ST_MSG_OUT);
        atn_pin <= 1'b0;
        // Two edges for the synchroniser to see Attention gone
        repeat (2) @(posedge core_clk);
        send(8'h08, 1'b0);
      end
      wait_phase(ST_DATA);
      if (k == 0)
      begin
        exp_q.push_back(MSG_DISCONNECT);
        exp_q.push_back(8'hC0);
        apb(1'b1, REG_CTRL, CTRL_RESET | 32'h2);
        wait_phase(ST_BUS_FREE);
        check("disc_busy", {31'h0, busy_oe}, 32'h0);
        apb(1'b1, REG_CTRL, CTRL_RESET | 32'h4);
        wait_phase(ST_DATA);
      end
      exp_q.push_back(8'h00);
      exp_q.push_back(MSG_COMPLETE);
      apb(1'b1, REG_CTRL, CTRL_RESET | 32'h8);
      wait_phase(ST_BUS_FREE);
      apb(1'b1, REG_CTRL, CTRL_RESET);
    end
    // Sixteen bad first CDB bytes, no disconnect permission
    select();
    send(8'h80, 1'b0);
    wait_phase(ST_COMMAND);
    for (int i = 0; i < 16; i++)
    begin
      if (i < 15)
        exp_q.push_back(MSG_RESTORE);
      else
      begin
        exp_q.push_back(STATUS_CHECK);
        exp_q.push_back(MSG_COMPLETE);
      end
      send(8'h08, 1'b1);
      if (i < 15)
        wait_phase(ST_COMMAND);
    end
    wait_phase(ST_BUS_FREE);
    check("busy_released", {31'h0, busy_oe}, 32'h0);
    apb(1'b0, REG_SENSE, 32'h0);
    rd2 = rd;
    check("sense", {4'h0, rd[27:0]}, {4'h0, SENSE_ABORTED, ASC_PARITY_CDB, ASCQ_ZERO, FSC_CDB_RETRY});
    apb(1'b0, REG_SENSE, 32'h0);
    check("sense_again", rd, rd2);
    // Retry count starts afresh on a new selection
    exp_q.push_back(MSG_RESTORE);
    select();
    send(8'h80, 1'b0);
    wait_phase(ST_COMMAND);
    send(8'h08, 1'b1);
    wait_phase(ST_COMMAND);
    // Sense command start keeps the sense data
    cmd_is_sense <= 1'b1;
    send(8'h03, 1'b0);
    apb(1'b0, REG_SENSE, 32'h0);
    check("sense_kept", rd, rd2);
    cmd_is_sense <= 1'b0;
    exp_q.push_back(MSG_RESTORE);
    send(8'h08, 1'b1);
    wait_phase(ST_COMMAND);
    apb(1'b0, REG_RETRY, 32'h0);
    check("retry_count", rd, 32'h2);
    send(8'h08, 1'b0);
    apb(1'b0, REG_SENSE, 32'h0);
    check("sense_cleared", rd, 32'h0);
    repeat (20) @(posedge core_clk);
    check("tx_left", exp_q.size(), 32'h0);
    end_of_test();
  end
endmodule
